//--- design/idc_pkg.sv
// constants and carrier types for the bridge decode and control bank
// Function
// RL1 - eight add-on bits forward 16K blocks
// RL2 - hole start holds address bits 23:16
// RL3 - hole enable blocks forwarding, resets zero
// RL4 - hole size thermometer, 64K to 8M
// RL5 - hole match ignores bits covered by size
// RL6 - alternate mode reset bit pulses 1 ms
// RL7 - clock select divides pci clock
// RL8 - extended bios range drives chip select
// RL9 - lower bios ranges drive chip select
// RL10 - upper bios ranges, reset enabled
// RL11 - write protect suppresses bios select on writes
// RL12 - keyboard ports give encoded select 11
// RL13 - rtc ports give encoded select 01
// RL14 - enable makes shared pin coprocessor error
// RL15 - port 92 handled internally when enabled
// RL16 - keyboard reset pulses init or hard reset
// RL17 - gate a20 toggles on keyboard command
// RL18 - io recovery adds 4 or 8 clocks
// RL19 - enabled irq event ends power active
// RL20 - software uses break enables in pc mode
package idc_pkg;
   localparam logic [7:0] OFS_ADDON = 8'h40;
   localparam logic [7:0] OFS_HOLE_START = 8'h41;
   localparam logic [7:0] OFS_HOLE_SIZE = 8'h42;
   localparam logic [7:0] OFS_CLK_DIV = 8'h43;
   localparam logic [7:0] OFS_SYS_CTRL = 8'h44;
   localparam logic [7:0] OFS_BUS_TIMING = 8'h45;
   localparam logic [7:0] OFS_IRQ_WAKE = 8'h46;
   localparam logic [7:0] OFS_CHIP_SEL = 8'h4d;
   localparam logic [7:0] RST_ADDON = 8'h00;
   localparam logic [7:0] RST_HOLE_START = 8'h00;
   localparam logic [7:0] RST_HOLE_SIZE = 8'h00;
   localparam logic [7:0] RST_CLK_DIV = 8'h00;
   localparam logic [7:0] RST_CHIP_SEL = 8'h33;
   localparam logic [7:0] RST_SYS_CTRL = 8'h04;
   localparam logic [7:0] RST_BUS_TIMING = 8'h00;
   localparam logic [7:0] RST_IRQ_WAKE = 8'h00;
   // writable bits; reserved bits read zero
   localparam logic [7:0] WM_CLK_DIV = 8'h07;
   localparam logic [7:0] WM_CHIP_SEL = 8'hf3;
   localparam logic [7:0] WM_SYS_CTRL = 8'h57;
   localparam logic [7:0] WM_BUS_TIMING = 8'h06;
   localparam int BIT_HOLE_EN = 7;
   localparam int BIT_BUS_RST = 3;
   localparam int BIT_EXT_BIOS = 7;
   localparam int BIT_LOW_BIOS = 6;
   localparam int BIT_BIOS_WP = 5;
   localparam int BIT_UP_BIOS = 4;
   localparam int BIT_KBD_SEL = 1;
   localparam int BIT_RTC_SEL = 0;
   localparam int BIT_REFRESH = 6;
   localparam int BIT_FPU_ERR = 4;
   localparam int BIT_P92 = 2;
   localparam int BIT_KBD_RST = 1;
   localparam int BIT_A20 = 0;
   localparam int BIT_IO_REC = 2;
   localparam int BIT_EXT_ALE = 1;
   localparam logic [9:0] ADDON_BASE_BLK = 10'h030;
   localparam logic [15:0] IO_KBD_MASKED = 16'h0060;
   localparam logic [15:0] IO_RTC_BASE = 16'h0070;
   localparam logic [15:0] IO_PORT92 = 16'h0092;
   localparam logic [1:0] XSEL_NONE = 2'b00;
   localparam logic [1:0] XSEL_RTC = 2'b01;
   localparam logic [1:0] XSEL_ROM_KBD = 2'b11;
   localparam logic [3:0] IO_REC_16 = 4'h4;
   localparam logic [3:0] IO_REC_8 = 4'h8;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned RESET_PULSE_US = 1000;
   localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_US * CLK_MHZ;
   localparam int unsigned INIT_MIN_CLKS = 4;
   localparam int unsigned INIT_CYCLES = INIT_MIN_CLKS + 1;
   localparam int TMR_W = 17;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } idc_cfg_req_t;

   typedef struct packed {
      logic valid;
      logic mem;
      logic io;
      logic write;
      logic wide16;
      logic [31:0] addr;
   } idc_host_req_t;

   typedef struct packed {
      logic valid;
      logic [23:0] addr;
   } idc_isa_req_t;
endpackage : idc_pkg

//--- design/idc_bridge_ctrl.sv
// bridge decode and control register bank with its pulse timers
`timescale 1ns/1ps
`default_nettype none

module idc_pulse_tmr
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [idc_pkg::TMR_W-1:0] len,
   output logic busy
);
   logic [idc_pkg::TMR_W-1:0] cnt_q;
   logic [idc_pkg::TMR_W-1:0] cnt_d;

   always_comb
   begin
      cnt_d = cnt_q;
      if (start && cnt_q == '0)
      begin
         cnt_d = len;
      end
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign busy = (cnt_q != '0);
endmodule : idc_pulse_tmr

module idc_bridge_ctrl
#(
   parameter int unsigned RESET_PULSE_CYCLES = idc_pkg::RESET_PULSE_CYCLES,
   parameter bit UPPER_BIOS_WIDE = 1'b0
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire idc_pkg::idc_cfg_req_t cfg_req,
   output logic [7:0] cfg_rdata,
   input wire idc_pkg::idc_isa_req_t isa_req,
   output logic isa_fwd_pci,
   input wire idc_pkg::idc_host_req_t host_req,
   output logic bios_chip_select_n,
   output logic [1:0] encoded_chip_select,
   output logic port92_internal,
   output logic io_pass_to_isa,
   output logic [3:0] io_recovery_clks,
   output logic isa_clk,
   output logic pci_reset_n,
   output logic isa_bus_reset,
   input wire logic kbd_reset_cmd,
   input wire logic kbd_a20_cmd,
   output logic cpu_init,
   output logic hard_reset_out_n,
   output logic gate_a20,
   input wire logic alternate_host_mode,
   input wire logic coprocessor_error_in,
   output logic coprocessor_error,
   input wire logic [7:0] irq_in,
   input wire logic pm_sleep_req,
   output logic power_mgmt_active_n,
   output logic isa_refresh_en,
   output logic extended_ale
);
   logic [7:0] addon_q, addon_d, hole_start_q, hole_start_d, hole_size_q, hole_size_d;
   logic [7:0] clk_div_q, clk_div_d, chip_sel_q, chip_sel_d, sys_ctrl_q, sys_ctrl_d;
   logic [7:0] bus_timing_q, bus_timing_d, irq_wake_q, irq_wake_d, rdata_q, rdata_d;
   logic [9:0] pin_s1_q, pin_s2_q, irq_prev_q;
   logic alt_mode, pc_mode, coprocessor_error_in_s, bus_rst_busy, init_busy, hres_busy;
   logic bus_rst_start;
   logic [6:0] hsz;
   logic hole_hit, addon_hit, fwd_d, fwd_q;
   logic bios_hit, ext_hit, low_hit, up_hit, kbd_hit, rtc_hit, p92_hit;
   logic bios_chip_select_n_d, bios_chip_select_n_q, p92_d, p92_q, pass_d, pass_q;
   logic [1:0] xsel_d, xsel_q;
   logic [3:0] rec_d, rec_q;
   logic [3:0] div_n, div_cnt_q, div_cnt_d;
   logic isa_clk_d, isa_clk_q, a20_d, a20_q, power_mgmt_active_d, power_mgmt_active_q;
   logic [7:0] irq_events;
   logic [15:0] ioa;
   logic [31:0] ma;

   // two-flop capture of the mode strap, error pin and irq lines
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         irq_prev_q <= '0;
      end
      else
      begin
         pin_s1_q <= {alternate_host_mode, coprocessor_error_in, irq_in};
         pin_s2_q <= pin_s1_q;
         irq_prev_q <= pin_s2_q;
      end
   end

   assign alt_mode = pin_s2_q[9];
   assign pc_mode = !pin_s2_q[9];
   assign coprocessor_error_in_s = pin_s2_q[8];

   // configuration writes and reads
   always_comb
   begin
      addon_d = addon_q;
      hole_start_d = hole_start_q;
      hole_size_d = hole_size_q;
      clk_div_d = clk_div_q;
      chip_sel_d = chip_sel_q;
      sys_ctrl_d = sys_ctrl_q;
      bus_timing_d = bus_timing_q;
      irq_wake_d = irq_wake_q;
      rdata_d = rdata_q;
      if (cfg_req.wr)
      begin
         case (cfg_req.addr)
            idc_pkg::OFS_ADDON: addon_d = cfg_req.wdata; // RL1
            idc_pkg::OFS_HOLE_START: hole_start_d = cfg_req.wdata; // RL2
            idc_pkg::OFS_HOLE_SIZE: hole_size_d = cfg_req.wdata; // RL3
            idc_pkg::OFS_CLK_DIV: clk_div_d = cfg_req.wdata & idc_pkg::WM_CLK_DIV; // RL7
            idc_pkg::OFS_CHIP_SEL: chip_sel_d = cfg_req.wdata & idc_pkg::WM_CHIP_SEL;
            idc_pkg::OFS_SYS_CTRL: sys_ctrl_d = cfg_req.wdata & idc_pkg::WM_SYS_CTRL;
            idc_pkg::OFS_BUS_TIMING: bus_timing_d = cfg_req.wdata & idc_pkg::WM_BUS_TIMING;
            idc_pkg::OFS_IRQ_WAKE: irq_wake_d = cfg_req.wdata;
            default: addon_d = addon_q;
         endcase
      end
      if (cfg_req.rd)
      begin
         case (cfg_req.addr)
            idc_pkg::OFS_ADDON: rdata_d = addon_q;
            idc_pkg::OFS_HOLE_START: rdata_d = hole_start_q;
            idc_pkg::OFS_HOLE_SIZE: rdata_d = hole_size_q;
            idc_pkg::OFS_CLK_DIV: rdata_d = {4'h0, bus_rst_busy, clk_div_q[2:0]}; // RL6
            idc_pkg::OFS_CHIP_SEL: rdata_d = chip_sel_q;
            idc_pkg::OFS_SYS_CTRL: rdata_d = sys_ctrl_q;
            idc_pkg::OFS_BUS_TIMING: rdata_d = bus_timing_q;
            idc_pkg::OFS_IRQ_WAKE: rdata_d = irq_wake_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         addon_q <= idc_pkg::RST_ADDON;
         hole_start_q <= idc_pkg::RST_HOLE_START;
         hole_size_q <= idc_pkg::RST_HOLE_SIZE; // RL3
         clk_div_q <= idc_pkg::RST_CLK_DIV;
         chip_sel_q <= idc_pkg::RST_CHIP_SEL; // RL10
         sys_ctrl_q <= idc_pkg::RST_SYS_CTRL;
         bus_timing_q <= idc_pkg::RST_BUS_TIMING;
         irq_wake_q <= idc_pkg::RST_IRQ_WAKE;
         rdata_q <= 8'h00;
      end
      else
      begin
         addon_q <= addon_d;
         hole_start_q <= hole_start_d;
         hole_size_q <= hole_size_d;
         clk_div_q <= clk_div_d;
         chip_sel_q <= chip_sel_d;
         sys_ctrl_q <= sys_ctrl_d;
         bus_timing_q <= bus_timing_d;
         irq_wake_q <= irq_wake_d;
         rdata_q <= rdata_d;
      end
   end

   assign cfg_rdata = rdata_q;

   // self-clearing bus reset, alternate mode only
   assign bus_rst_start = cfg_req.wr && cfg_req.addr == idc_pkg::OFS_CLK_DIV
      && cfg_req.wdata[idc_pkg::BIT_BUS_RST] && alt_mode; // RL6

   idc_pulse_tmr u_bus_rst
   (
      .clk(clk),
      .resetn(resetn),
      .start(bus_rst_start),
      .len(idc_pkg::TMR_W'(RESET_PULSE_CYCLES)),
      .busy(bus_rst_busy)
   );

   idc_pulse_tmr u_init
   (
      .clk(clk),
      .resetn(resetn),
      .start(kbd_reset_cmd && sys_ctrl_q[idc_pkg::BIT_KBD_RST] && pc_mode), // RL16
      .len(idc_pkg::TMR_W'(idc_pkg::INIT_CYCLES)),
      .busy(init_busy)
   );

   idc_pulse_tmr u_hres
   (
      .clk(clk),
      .resetn(resetn),
      .start(kbd_reset_cmd && sys_ctrl_q[idc_pkg::BIT_KBD_RST] && alt_mode), // RL16
      .len(idc_pkg::TMR_W'(RESET_PULSE_CYCLES)),
      .busy(hres_busy)
   );

   assign pci_reset_n = !bus_rst_busy;
   assign isa_bus_reset = bus_rst_busy;
   assign cpu_init = init_busy;
   assign hard_reset_out_n = !hres_busy;

   // isa memory forwarding decode
   assign hsz = hole_size_q[6:0];
   always_comb
   begin
      addon_hit = isa_req.addr[23:17] == idc_pkg::ADDON_BASE_BLK[9:3]
         && addon_q[isa_req.addr[16:14]]; // RL1
      hole_hit = ((isa_req.addr[23:16] ^ hole_start_q) & ~{1'b0, hsz}) == 8'h00 // RL5
         && (hsz & (hsz + 7'h01)) == 7'h00; // RL4
      fwd_d = isa_req.valid && addon_hit && !(hole_hit && hole_size_q[idc_pkg::BIT_HOLE_EN]); // RL3
   end

   // host side chip select decode
   assign ma = host_req.addr;
   assign ioa = host_req.addr[15:0];
   always_comb
   begin
      ext_hit = chip_sel_q[idc_pkg::BIT_EXT_BIOS] && ma >= 32'hfff80000 && ma <= 32'hfffdffff; // RL8
      low_hit = chip_sel_q[idc_pkg::BIT_LOW_BIOS] && (ma[31:16] == 16'hfffe
         || ma[31:16] == 16'hffee || ma[31:16] == 16'h000e); // RL9
      if (UPPER_BIOS_WIDE)
      begin
         up_hit = ma[31:16] == 16'h000f || ma >= 32'hff800000;
      end
      else
      begin
         up_hit = ma[31:16] == 16'hffff || ma[31:16] == 16'hffef || ma[31:16] == 16'h000f;
      end
      up_hit = up_hit && chip_sel_q[idc_pkg::BIT_UP_BIOS]; // RL10
      bios_hit = host_req.valid && host_req.mem && (ext_hit || low_hit || up_hit)
         && !(host_req.write && chip_sel_q[idc_pkg::BIT_BIOS_WP]); // RL11
      kbd_hit = host_req.valid && host_req.io && pc_mode && chip_sel_q[idc_pkg::BIT_KBD_SEL]
         && (ioa & 16'hfff9) == idc_pkg::IO_KBD_MASKED; // RL12
      rtc_hit = host_req.valid && host_req.io && pc_mode && chip_sel_q[idc_pkg::BIT_RTC_SEL]
         && ioa[15:3] == idc_pkg::IO_RTC_BASE[15:3]; // RL13
      p92_hit = host_req.valid && host_req.io && ioa == idc_pkg::IO_PORT92;
      bios_chip_select_n_d = !(bios_hit && alt_mode);
      xsel_d = idc_pkg::XSEL_NONE;
      if ((bios_hit && pc_mode) || kbd_hit)
      begin
         xsel_d = idc_pkg::XSEL_ROM_KBD; // RL8
      end
      else if (rtc_hit)
      begin
         xsel_d = idc_pkg::XSEL_RTC; // RL13
      end
      p92_d = p92_hit && sys_ctrl_q[idc_pkg::BIT_P92]; // RL15
      pass_d = p92_hit && !sys_ctrl_q[idc_pkg::BIT_P92]; // RL15
      rec_d = 4'h0;
      if (host_req.valid && host_req.io && bus_timing_q[idc_pkg::BIT_IO_REC])
      begin
         rec_d = host_req.wide16 ? idc_pkg::IO_REC_16 : idc_pkg::IO_REC_8; // RL18
      end
   end

   // isa clock divider
   always_comb
   begin
      case (clk_div_q[2:0])
         3'h0: div_n = 4'h4;
         3'h1: div_n = 4'h3;
         3'h2: div_n = 4'h2;
         3'h4: div_n = 4'h6;
         3'h5: div_n = 4'h8;
         default: div_n = 4'h4;
      endcase
      div_cnt_d = (div_cnt_q + 4'h1 >= div_n) ? 4'h0 : div_cnt_q + 4'h1; // RL7
      isa_clk_d = div_cnt_d < (div_n >> 1); // RL7
   end

   // gate a20 and power management
   assign irq_events = pin_s2_q[7:0] & ~irq_prev_q[7:0] & irq_wake_q; // RL19
   always_comb
   begin
      a20_d = a20_q;
      if (kbd_a20_cmd && sys_ctrl_q[idc_pkg::BIT_A20] && pc_mode)
      begin
         a20_d = !a20_q; // RL17
      end
      power_mgmt_active_d = power_mgmt_active_q;
      if (pm_sleep_req)
      begin
         power_mgmt_active_d = 1'b1;
      end
      if (pc_mode && irq_events != 8'h00)
      begin
         power_mgmt_active_d = 1'b0; // RL19 RL20
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_q <= 1'b0;
         bios_chip_select_n_q <= 1'b1;
         xsel_q <= idc_pkg::XSEL_NONE;
         p92_q <= 1'b0;
         pass_q <= 1'b0;
         rec_q <= 4'h0;
         div_cnt_q <= 4'h0;
         isa_clk_q <= 1'b0;
         a20_q <= 1'b0;
         power_mgmt_active_q <= 1'b0;
      end
      else
      begin
         fwd_q <= fwd_d;
         bios_chip_select_n_q <= bios_chip_select_n_d;
         xsel_q <= xsel_d;
         p92_q <= p92_d;
         pass_q <= pass_d;
         rec_q <= rec_d;
         div_cnt_q <= div_cnt_d;
         isa_clk_q <= isa_clk_d;
         a20_q <= a20_d;
         power_mgmt_active_q <= power_mgmt_active_d;
      end
   end

   assign isa_fwd_pci = fwd_q;
   assign bios_chip_select_n = bios_chip_select_n_q;
   assign encoded_chip_select = xsel_q;
   assign port92_internal = p92_q;
   assign io_pass_to_isa = pass_q;
   assign io_recovery_clks = rec_q;
   assign isa_clk = isa_clk_q;
   assign gate_a20 = a20_q;
   assign power_mgmt_active_n = !power_mgmt_active_q;
   assign coprocessor_error = sys_ctrl_q[idc_pkg::BIT_FPU_ERR] && coprocessor_error_in_s; // RL14
   assign isa_refresh_en = sys_ctrl_q[idc_pkg::BIT_REFRESH];
   assign extended_ale = bus_timing_q[idc_pkg::BIT_EXT_ALE];
endmodule : idc_bridge_ctrl

`default_nettype wire

//--- test/idc_host_model.sv
// configuration master model driving the register bank
`timescale 1ns/1ps
`default_nettype none
module idc_host_model
(
   input wire logic clk,
   input wire logic alt_mode,
   input wire logic [7:0] rdata,
   output var idc_pkg::idc_cfg_req_t req
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (!(alt_mode && a == idc_pkg::OFS_IRQ_WAKE))
      begin
         @(negedge clk);
         req <= '{1'b0, 1'b1, a, d};
         @(negedge clk);
         req <= '0;
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req <= '{1'b1, 1'b0, a, 8'h00};
      @(negedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
   endtask : rd
endmodule : idc_host_model
`default_nettype wire

//--- test/idc_bridge_ctrl_checker.sv
// port assertions for the bridge decode and control bank
`timescale 1ns/1ps
`default_nettype none
module idc_bridge_ctrl_checker
(
   input wire logic clk,
   input wire logic resetn,
   input wire idc_pkg::idc_cfg_req_t cfg_req,
   input wire idc_pkg::idc_isa_req_t isa_req,
   input wire logic isa_fwd_pci,
   input wire idc_pkg::idc_host_req_t host_req,
   input wire logic bios_chip_select_n,
   input wire logic [1:0] encoded_chip_select,
   input wire logic port92_internal,
   input wire logic io_pass_to_isa,
   input wire logic [3:0] io_recovery_clks,
   input wire logic pci_reset_n,
   input wire logic isa_bus_reset,
   input wire logic kbd_reset_cmd,
   input wire logic kbd_a20_cmd,
   input wire logic cpu_init,
   input wire logic hard_reset_out_n,
   input wire logic gate_a20
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence init_run;
      cpu_init [*5] ##1 !cpu_init;
   endsequence
   a_init_length: assert property ($rose(cpu_init) |-> init_run)
      else $error("init pulse length wrong");
   a_init_cause: assert property ($rose(cpu_init) |-> $past(kbd_reset_cmd))
      else $error("init without command");
   a_hard_cause: assert property ($fell(hard_reset_out_n) |-> $past(kbd_reset_cmd))
      else $error("hard reset without command");
   a_a20_cause: assert property ((gate_a20 != $past(gate_a20)) |-> $past(kbd_a20_cmd))
      else $error("gate a20 moved without command");
   a_bus_reset_pair: assert property (isa_bus_reset == !pci_reset_n)
      else $error("bus resets disagree");
   a_bus_reset_cause: assert property ($rose(isa_bus_reset) |->
      $past(cfg_req.wr && cfg_req.addr == idc_pkg::OFS_CLK_DIV && cfg_req.wdata[idc_pkg::BIT_BUS_RST]))
      else $error("bus reset without divisor write");
   a_recovery_len: assert property ((io_recovery_clks != 4'h0) |-> $past(host_req.valid && host_req.io)
      && io_recovery_clks == ($past(host_req.wide16) ? idc_pkg::IO_REC_16 : idc_pkg::IO_REC_8))
      else $error("recovery count wrong");
   a_rom_mem: assert property (!bios_chip_select_n |-> $past(host_req.valid && host_req.mem)
      && encoded_chip_select == idc_pkg::XSEL_NONE)
      else $error("rom select without memory access");
   a_rtc_ports: assert property ((encoded_chip_select == idc_pkg::XSEL_RTC) |-> $past(host_req.io)
      && $past(host_req.addr[15:3]) == 13'h000e)
      else $error("rtc select off its ports");
   a_port92_addr: assert property ((port92_internal || io_pass_to_isa) |->
      !(port92_internal && io_pass_to_isa) && $past(host_req.addr[15:0]) == idc_pkg::IO_PORT92)
      else $error("port 92 outputs wrong");
   a_fwd_valid: assert property (isa_fwd_pci |-> $past(isa_req.valid))
      else $error("forward without request");
endmodule : idc_bridge_ctrl_checker
bind idc_bridge_ctrl idc_bridge_ctrl_checker i_idc_bridge_ctrl_checker (.clk, .resetn, .cfg_req, .isa_req, .isa_fwd_pci,
   .host_req, .bios_chip_select_n, .encoded_chip_select, .port92_internal, .io_pass_to_isa, .io_recovery_clks,
   .pci_reset_n, .isa_bus_reset, .kbd_reset_cmd, .kbd_a20_cmd, .cpu_init, .hard_reset_out_n, .gate_a20);
`default_nettype wire

//--- test/idc_bridge_ctrl_bench.sv
// self-checking bench for the bridge decode and control bank
`timescale 1ns/1ps
`default_nettype none
module idc_bridge_ctrl_bench;
   logic clk = 1'b0, resetn = 1'b0, mode = 1'b0, kr = 1'b0, ka = 1'b0, fe = 1'b0, sl = 1'b0;
   logic [7:0] irq = 8'h00, rdata;
   idc_pkg::idc_cfg_req_t cfg;
   idc_pkg::idc_isa_req_t isa = '0;
   idc_pkg::idc_host_req_t host = '0;
   logic fwd, csn, p92i, p92p, iclk, prn, ibr, init, hrn, a20, fpe, pman, refr, eale;
   logic [1:0] enc;
   logic [3:0] rec;
   int fails = 0, total_checks = 0, cyc = 0;
   idc_host_model hm (.clk(clk), .alt_mode(mode), .rdata(rdata), .req(cfg));
   idc_bridge_ctrl #(.RESET_PULSE_CYCLES(20), .UPPER_BIOS_WIDE(1'b0)) i_idc_bridge_ctrl (.clk(clk),
      .resetn(resetn), .cfg_req(cfg), .cfg_rdata(rdata), .isa_req(isa), .isa_fwd_pci(fwd), .host_req(host),
      .bios_chip_select_n(csn), .encoded_chip_select(enc), .port92_internal(p92i), .io_pass_to_isa(p92p),
      .io_recovery_clks(rec), .isa_clk(iclk), .pci_reset_n(prn), .isa_bus_reset(ibr), .kbd_reset_cmd(kr),
      .kbd_a20_cmd(ka), .cpu_init(init), .hard_reset_out_n(hrn), .gate_a20(a20), .alternate_host_mode(mode),
      .coprocessor_error_in(fe), .coprocessor_error(fpe), .irq_in(irq), .pm_sleep_req(sl),
      .power_mgmt_active_n(pman), .isa_refresh_en(refr), .extended_ale(eale));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hreq(input logic m, input logic io, input logic w, input logic w16, input logic [31:0] a);
      @(negedge clk);
      host <= '{1'b1, m, io, w, w16, a};
      @(negedge clk);
      host <= '0;
   endtask : hreq
   task automatic ireq(input logic [23:0] a, input logic [7:0] exp);
      @(negedge clk);
      isa <= '{1'b1, a};
      @(negedge clk);
      isa <= '0;
      chk(fwd, exp);
   endtask : ireq
   task automatic run_len(ref logic s, input logic lvl, output int n);
      n = 0;
      for (int i = 0; i < 40 && s !== lvl; i++) @(negedge clk);
      while (s === lvl && n < 200)
      begin
         @(negedge clk);
         n++;
      end
   endtask : run_len
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic t_defaults();
      logic [7:0] ofs [9] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4d, 8'h50};
      logic [7:0] rst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h33, 8'h00};
      logic [7:0] d;
      for (int i = 0; i < 9; i++)
      begin
         hm.rd(ofs[i], d);
         chk(d, rst[i]);
      end
   endtask : t_defaults
   task automatic t_forward();
      hm.wr(8'h40, 8'h81);
      ireq(24'h0c0000, 8'h01);
      ireq(24'h0c4000, 8'h00);
      ireq(24'h0dc000, 8'h01);
      hm.wr(8'h40, 8'hff);
      hm.wr(8'h41, 8'h0c);
      hm.wr(8'h42, 8'h80);
      ireq(24'h0c4000, 8'h00);
      ireq(24'h0d0000, 8'h01);
      hm.wr(8'h42, 8'h81);
      ireq(24'h0d0000, 8'h00);
      hm.wr(8'h42, 8'h85);
      ireq(24'h0c0000, 8'h01);
      hm.wr(8'h42, 8'h01);
      ireq(24'h0c0000, 8'h01);
   endtask : t_forward
   task automatic t_clock();
      logic [2:0] c [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
      int dv [6] = '{4, 3, 2, 6, 8, 4};
      int x, a, b;
      for (int i = 0; i < 6; i++)
      begin
         hm.wr(8'h43, {5'h00, c[i]});
         repeat (20) @(negedge clk);
         run_len(iclk, 1'b0, x);
         run_len(iclk, 1'b1, a);
         run_len(iclk, 1'b0, b);
         chk(8'(a + b), 8'(dv[i]));
      end
   endtask : t_clock
   task automatic t_selects();
      hreq(1'b1, 1'b0, 1'b0, 1'b0, 32'hffff0000);
      chk({csn, enc}, 8'h07);
      hreq(1'b1, 1'b0, 1'b1, 1'b0, 32'hffff0000);
      chk({csn, enc}, 8'h04);
      hreq(1'b1, 1'b0, 1'b0, 1'b0, 32'hfff80000);
      chk(enc, 8'h00);
      hm.wr(8'h4d, 8'hc3);
      hreq(1'b1, 1'b0, 1'b0, 1'b0, 32'hfff80000);
      chk(enc, 8'h03);
      hreq(1'b1, 1'b0, 1'b1, 1'b0, 32'h000e0000);
      chk(enc, 8'h03);
      hreq(1'b1, 1'b0, 1'b0, 1'b0, 32'h000f0000);
      chk(enc, 8'h00);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000066);
      chk(enc, 8'h03);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000077);
      chk(enc, 8'h01);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000078);
      chk(enc, 8'h00);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000092);
      chk({p92i, p92p}, 8'h02);
      hm.wr(8'h44, 8'h00);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000092);
      chk({p92i, p92p}, 8'h01);
   endtask : t_selects
   task automatic t_recovery();
      logic [7:0] d;
      hm.wr(8'h45, 8'hff);
      hm.rd(8'h45, d);
      chk(d, 8'h06);
      chk(eale, 8'h01);
      hreq(1'b0, 1'b1, 1'b0, 1'b1, 32'h00000300);
      chk(rec, 8'h04);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000300);
      chk(rec, 8'h08);
      hm.wr(8'h45, 8'h00);
      chk(eale, 8'h00);
      hreq(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000300);
      chk(rec, 8'h00);
   endtask : t_recovery
   task automatic t_keyboard_pm();
      int n;
      hm.wr(8'h44, 8'h53);
      chk(refr, 8'h01);
      pulse(kr);
      run_len(init, 1'b1, n);
      chk(8'(n), 8'h05);
      pulse(ka);
      chk(a20, 8'h01);
      pulse(ka);
      chk(a20, 8'h00);
      fe = 1'b1;
      repeat (4) @(negedge clk);
      chk(fpe, 8'h01);
      hm.wr(8'h44, 8'h03);
      chk(fpe, 8'h00);
      chk(refr, 8'h00);
      hm.wr(8'h46, 8'h01);
      pulse(sl);
      chk(pman, 8'h00);
      irq = 8'h02;
      repeat (6) @(negedge clk);
      chk(pman, 8'h00);
      irq = 8'h03;
      repeat (6) @(negedge clk);
      chk(pman, 8'h01);
   endtask : t_keyboard_pm
   task automatic t_alternate();
      logic [7:0] d;
      int n;
      mode = 1'b1;
      repeat (4) @(negedge clk);
      hreq(1'b1, 1'b0, 1'b0, 1'b0, 32'h000e0000);
      chk({csn, enc}, 8'h00);
      hm.wr(8'h43, 8'h08);
      chk({ibr, prn}, 8'h02);
      run_len(ibr, 1'b1, n);
      chk(8'(n), 8'h14);
      hm.rd(8'h43, d);
      chk(d, 8'h00);
      pulse(kr);
      run_len(hrn, 1'b0, n);
      chk(8'(n), 8'h14);
   endtask : t_alternate
   initial
   begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      t_defaults();
      t_forward();
      t_clock();
      t_selects();
      t_recovery();
      t_keyboard_pm();
      t_alternate();
      report_and_stop();
   end
endmodule : idc_bridge_ctrl_bench
`default_nettype wire
